/* File: design/epv_defs.svh */
`ifndef EPV_DEFS_SVH
`define EPV_DEFS_SVH

// Array sizes and address widths.
`define EPV_ADDR_W        12
`define EPV_CODE_DEPTH    13'h1_000
`define EPV_ENC_DEPTH     6'h20
`define EPV_ENC_LAST      12'h01F

// Program strobe pulses that commit one location, and the last count before it.
`define EPV_PULSES        5'h19
`define EPV_PULSE_LAST    5'h18

// Mode pin codes, ordered enable_select, mode_select_a, mode_select_b, mode_select_c.
`define EPV_CODE_SIG      4'h0
`define EPV_CODE_PGM      4'hB
`define EPV_CODE_VER      4'h3
`define EPV_CODE_ENC      4'hA
`define EPV_CODE_SEC1     4'hF
`define EPV_CODE_SEC2     4'hC

// Signature locations and the value of an erased byte.
`define EPV_SIG_ADDR0     12'h030
`define EPV_SIG_ADDR1     12'h031
`define EPV_ERASED        8'hFF

// Identity bytes; these values are arbitrary.
`define EPV_ID_MAKER      8'h5A
`define EPV_ID_PART       8'hA5

// Output settle bound: 48 oscillator periods at the 6 MHz upper rate, in ns.
`define EPV_OSC_PERIODS   32'h0000_0030
`define EPV_OSC_MIN_NS    32'h0000_00A6
`define EPV_CLK_NS        32'h0000_0005

`endif

/* File: design/epv_pkg.sv */
`include "epv_defs.svh"

package epv_pkg;

   // Operating mode, one-hot.
   typedef enum logic [6:0] {
      EPV_IDLE     = 7'h01,
      EPV_SIG      = 7'h02,
      EPV_PGM_CODE = 7'h04,
      EPV_VER_CODE = 7'h08,
      EPV_PGM_ENC  = 7'h10,
      EPV_PGM_SEC1 = 7'h20,
      EPV_PGM_SEC2 = 7'h40
   } epv_mode_t;

   // All pin inputs of the port, sampled together.
   typedef struct packed {
      logic                     rst_pin;   // Reset pin level.
      logic                     fetch;     // Fetch strobe level.
      logic                     strobe;    // Program strobe level.
      logic                     vpp;       // Programming voltage present.
      logic                     en;        // Enable select.
      logic                     ma;        // Mode select a.
      logic                     mb;        // Mode select b.
      logic                     mc;        // Mode select c.
      logic [`EPV_ADDR_W-1:0]   addr;      // Address from ports 1 and 2.
      logic [7:0]               data;      // Data from port 0.
   } epv_pins_t;

endpackage : epv_pkg

/* File: design/epv_port.sv */
`timescale 1ns/1ps
`include "epv_defs.svh"
// What this block does
// (R1) Programmer presents address, data, program-code levels.
// (R2) Programmer pulses program strobe low 25 times.
// (R3) Pulses low 100us, high at least 10us; the programmer model uses 20 cycles (100 ns) low, 4 cycles (20 ns) high.
// (R4) Encryption table loaded at addresses 0 to 1FH.
// (R5) Verify output is XNOR with table byte.
// (R6) Encryption table is never readable on ports.
// (R7) Security bit set blocks code and table writes.
// (R8) Security bit 2 blocks code verify output.
// (R9) Verify drives addressed byte; programmer pulls up.
// (R10) Signature read at 030H and 031H gives identity.
// (R11) Mode decode from enable and select pins.
// (R12) Oscillator held at 4 to 6 MHz.
// (R13) Address and data held 48 periods around strobe; the programmer model holds them at least 32 cycles (160 ns).
// (R14) Enable select high 48 periods before voltage; the programmer model waits 32 cycles (160 ns).
// (R15) Port 0 valid or floating within 48 periods.
// (R16) Erased array reads all ones.
// (R17) Undefined mode codes neither write nor drive.
// (R18) Count pulses; commit only full unchanged sequence.
module epv_port (
   input  wire logic                   ref_clk,          // System clock, 200 MHz.
   input  wire logic                   nrst,             // Asynchronous reset, active low.
   input  wire logic                   reset_pin,        // Device reset pin level.
   input  wire logic                   fetch_strobe,     // Fetch strobe pin level.
   input  wire logic                   program_strobe,   // Program strobe pin level.
   input  wire logic                   program_voltage_pin, // High while voltage is applied.
   input  wire logic                   enable_select,    // Enable select pin.
   input  wire logic                   mode_select_a,    // Mode select a pin.
   input  wire logic                   mode_select_b,    // Mode select b pin.
   input  wire logic                   mode_select_c,    // Mode select c pin.
   input  wire logic [`EPV_ADDR_W-1:0] addr_pins,        // Address on ports 1 and 2.
   input  wire logic [7:0]             data_pins_in,     // Port 0 input level.
   output      logic [7:0]             data_pins_out,    // Port 0 output value.
   output      logic                   data_oe_n,        // Port 0 drive, low while driving.
   output      logic                   sec_bit1,         // Security bit 1 state.
   output      logic                   sec_bit2,         // Security bit 2 state.
   output      logic                   erase_busy        // High while the erase sweep runs.
);

   // Whole control state of the port.
   typedef struct packed {
      epv_pkg::epv_pins_t     s1;          // First synchroniser stage.
      epv_pkg::epv_pins_t     s2;          // Second synchroniser stage.
      epv_pkg::epv_pins_t     s3;          // Third synchroniser stage.
      epv_pkg::epv_pins_t     filt;        // Accepted pin levels.
      epv_pkg::epv_mode_t     mode;        // Decoded mode.
      logic [`EPV_ADDR_W+14:0] snap;       // Mode, address and data of the sequence.
      logic [4:0]             cnt;         // Completed strobe pulses.
      logic [31:0][7:0]       enc;         // Encryption table.
      logic                   enc_set;     // Table holds data.
      logic                   sec1;        // Security bit 1.
      logic                   sec2;        // Security bit 2.
      logic                   busy;        // Erase sweep running.
      logic [`EPV_ADDR_W-1:0] era;         // Erase sweep address.
      logic [7:0]             dout;        // Port 0 output register.
      logic                   oe_n;        // Port 0 drive register.
   } epv_state_t;

   logic [1:0]             rst_sync;       // Reset release synchroniser.
   logic                   rst_n;          // Synchronised reset.
   epv_state_t             st;             // Registered state.
   epv_state_t             next_st;        // Next state.
   epv_pkg::epv_pins_t     pins;           // Raw pins bundled.
   logic [7:0]             mem [0:`EPV_CODE_DEPTH-1]; // Code array.
   logic [7:0]             mem_q;          // Code array read data.
   logic                   mem_we;         // Code array write strobe.
   logic [`EPV_ADDR_W-1:0] mem_wa;         // Code array write address.
   logic [7:0]             mem_wd;         // Code array write data.
   logic                   rise;           // Filtered program strobe rising edge.
   logic                   commit;         // Full pulse sequence completed.
   logic [7:0]             enc_byte;       // Table byte chosen by address.

   // Accepts a new level per bit only once the second and third stages agree.
   function automatic epv_pkg::epv_pins_t filt_pins(input epv_pkg::epv_pins_t a,
                                                    input epv_pkg::epv_pins_t b,
                                                    input epv_pkg::epv_pins_t old);
      filt_pins = (a & b) | (old & (a | b));
   endfunction : filt_pins

   // Maps pin levels to a mode; anything outside the six codes is idle.
   function automatic epv_pkg::epv_mode_t decode(input epv_pkg::epv_pins_t p);
      decode = epv_pkg::EPV_IDLE;
      if (p.rst_pin && !p.fetch)
      begin
         case ({p.en, p.ma, p.mb, p.mc})                          // R11
            `EPV_CODE_SIG:  decode = epv_pkg::EPV_SIG;
            `EPV_CODE_PGM:  decode = epv_pkg::EPV_PGM_CODE;
            `EPV_CODE_VER:  decode = epv_pkg::EPV_VER_CODE;
            `EPV_CODE_ENC:  decode = epv_pkg::EPV_PGM_ENC;
            `EPV_CODE_SEC1: decode = epv_pkg::EPV_PGM_SEC1;
            `EPV_CODE_SEC2: decode = epv_pkg::EPV_PGM_SEC2;
            default:        decode = epv_pkg::EPV_IDLE;           // R17
         endcase
      end
   endfunction : decode

   // Releases the reset through two flip-flops.
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         rst_sync <= 2'h0;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_n = rst_sync[1];

   assign pins = '{rst_pin: reset_pin, fetch: fetch_strobe, strobe: program_strobe,
                   vpp: program_voltage_pin, en: enable_select, ma: mode_select_a,
                   mb: mode_select_b, mc: mode_select_c, addr: addr_pins,
                   data: data_pins_in};

   assign rise     = st.s3.strobe & st.s2.strobe & !st.filt.strobe;
   assign enc_byte = st.enc[st.filt.addr[4:0]];

   // Next state: synchronise, decode, count pulses, commit, and form port 0.
   always_comb
   begin
      next_st      = st;
      next_st.s1   = pins;
      next_st.s2   = st.s1;
      next_st.s3   = st.s2;
      next_st.filt = filt_pins(st.s2, st.s3, st.filt);
      next_st.mode = decode(st.filt);
      commit       = 1'b0;
      mem_we       = 1'b0;
      mem_wa       = st.filt.addr;
      mem_wd       = st.filt.data;
      // Sweeps the array to the erased value after reset.
      if (st.busy)
      begin
         mem_we      = 1'b1;                                       // R16
         mem_wa      = st.era;
         mem_wd      = `EPV_ERASED;
         next_st.era = st.era + 1'b1;
         next_st.busy = (st.era != `EPV_ADDR_W'(`EPV_CODE_DEPTH - 1'b1));
      end
      // Any change of mode, address or data restarts the pulse count.
      else if ({st.mode, st.filt.addr, st.filt.data} != st.snap
               || st.mode inside {epv_pkg::EPV_IDLE, epv_pkg::EPV_SIG, epv_pkg::EPV_VER_CODE}
               || !st.filt.vpp)
      begin
         next_st.snap = {st.mode, st.filt.addr, st.filt.data};
         next_st.cnt  = 5'h00;                                     // R18
      end
      // Each completed low pulse is counted; the last one commits.
      else if (rise)
      begin
         if (st.cnt == `EPV_PULSE_LAST)
         begin
            commit      = 1'b1;                                    // R18
            next_st.cnt = 5'h00;
         end
         else
            next_st.cnt = st.cnt + 1'b1;
      end
      if (commit)
      begin
         case (st.mode)
            epv_pkg::EPV_PGM_CODE: mem_we = !st.sec1 && !st.sec2;  // R7
            epv_pkg::EPV_PGM_ENC:
            begin
               // Only the table addresses land; locked once a security bit is set.
               if (!st.sec1 && !st.sec2 && st.filt.addr <= `EPV_ENC_LAST) // R7
               begin
                  next_st.enc[st.filt.addr[4:0]] = st.filt.data;   // R4
                  next_st.enc_set = 1'b1;
               end
            end
            epv_pkg::EPV_PGM_SEC1: next_st.sec1 = 1'b1;             // R7
            epv_pkg::EPV_PGM_SEC2: next_st.sec2 = 1'b1;             // R7
            default:               next_st.cnt  = 5'h00;
         endcase
      end
      // Port 0 drive: only the two read modes, never the table itself.
      next_st.oe_n = 1'b1;                                          // R17
      next_st.dout = `EPV_ERASED;                                   // R6
      if (!st.busy && st.mode == epv_pkg::EPV_VER_CODE && !st.sec2) // R8
      begin
         next_st.oe_n = 1'b0;                                       // R9
         next_st.dout = st.enc_set ? ~(mem_q ^ enc_byte) : mem_q;   // R5
      end
      else if (st.mode == epv_pkg::EPV_SIG)
      begin
         next_st.oe_n = 1'b0;                                       // R10
         if (st.filt.addr == `EPV_SIG_ADDR0)
            next_st.dout = `EPV_ID_MAKER;
         else if (st.filt.addr == `EPV_SIG_ADDR1)
            next_st.dout = `EPV_ID_PART;
      end
   end

   // Registers the whole state.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st      <= '0;
         st.mode <= epv_pkg::EPV_IDLE;
         st.busy <= 1'b1;
         st.enc  <= {32{`EPV_ERASED}};                             // R16
         st.dout <= `EPV_ERASED;
         st.oe_n <= 1'b1;
      end
      else
         st <= next_st;
   end

   // Code array with one write and one registered read port.
   always_ff @(posedge ref_clk)
   begin
      if (mem_we)
         mem[mem_wa] <= mem_wd;
      mem_q <= mem[st.filt.addr];
   end

   assign data_pins_out = st.dout;
   assign data_oe_n     = st.oe_n;
   assign sec_bit1      = st.sec1;
   assign sec_bit2      = st.sec2;
   assign erase_busy    = st.busy;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // A pulse sequence ends in one commit.
   sequence s_last_pulse;
      st.cnt == `EPV_PULSE_LAST ##0 rise;
   endsequence

   property p_commit_full;
      commit |-> !st.busy ##0 s_last_pulse;
   endproperty
   a_commit_full: assert property (p_commit_full) // R18
      else $error("Commit without full pulse count.");

   property p_count_restart;
      $changed(st.filt.addr) && !st.busy |=> st.cnt == 5'h00 [*2];
   endproperty
   a_count_restart: assert property (p_count_restart) // R18
      else $error("Pulse count survived an address change.");

   property p_locked;
      st.sec1 || st.sec2 |-> !(mem_we && !st.busy) && $stable(st.enc);
   endproperty
   a_locked: assert property (p_locked) // R7
      else $error("Write after security bit set.");

   property p_sec2_quiet;
      st.sec2 && st.mode == epv_pkg::EPV_VER_CODE |=> st.oe_n;
   endproperty
   a_sec2_quiet: assert property (p_sec2_quiet) // R8
      else $error("Code driven with security bit 2 set.");

   property p_drive_mode;
      !st.oe_n |-> $past(st.mode) inside {epv_pkg::EPV_VER_CODE, epv_pkg::EPV_SIG};
   endproperty
   a_drive_mode: assert property (p_drive_mode) // R17
      else $error("Port 0 driven outside a read mode.");

   property p_xnor;
      st.mode == epv_pkg::EPV_VER_CODE && st.enc_set && !st.sec2 && !st.busy
         |=> st.dout == ~($past(mem_q) ^ $past(enc_byte));
   endproperty
   a_xnor: assert property (p_xnor) // R5
      else $error("Verify byte not encrypted.");

   property p_signature;
      st.mode == epv_pkg::EPV_SIG && st.filt.addr == `EPV_SIG_ADDR1
         |=> !st.oe_n && st.dout == `EPV_ID_PART;
   endproperty
   a_signature: assert property (p_signature) // R10
      else $error("Wrong signature byte.");

   // Port 0 lets go two cycles after enable select is accepted high.
   property p_float;
      $rose(st.filt.en) |-> ##2 st.oe_n;
   endproperty
   a_float: assert property (p_float) // R15
      else $error("Port 0 still driven after enable select rose.");
endmodule : epv_port

/* File: verif/epv_port_bench.sv */
`timescale 1ns/1ps
`include "epv_defs.svh"
// Self-checking bench for the programming and verify port.
module epv_port_bench;
   localparam int LIMIT = 80000; // Cycle ceiling for the whole run.
   logic               ref_clk;         // 200 MHz clock.
   logic               nrst;            // Reset, active low.
   epv_pkg::epv_pins_t pins;            // Programmer pin levels.
   logic [7:0]         data_pins_out;   // Port 0 value from the device.
   logic               data_oe_n;       // Port 0 drive, low while driving.
   logic               sec_bit1;        // Security bit 1.
   logic               sec_bit2;        // Security bit 2.
   logic               erase_busy;      // Erase sweep running.
   int                 n_errors;        // Mismatches.
   int                 samples_checked; // Comparisons.
   int                 cycles;          // Elapsed cycles.
   logic [7:0]         v;               // Last byte read.
   logic               drove;           // Device drove port 0 on the last read.
   epv_programmer u_prog (.ref_clk(ref_clk), .data_pins_out(data_pins_out),
                          .data_oe_n(data_oe_n), .pins(pins));
   epv_port u_dut (.ref_clk(ref_clk), .nrst(nrst), .reset_pin(pins.rst_pin),
                   .fetch_strobe(pins.fetch), .program_strobe(pins.strobe),
                   .program_voltage_pin(pins.vpp), .enable_select(pins.en),
                   .mode_select_a(pins.ma), .mode_select_b(pins.mb),
                   .mode_select_c(pins.mc), .addr_pins(pins.addr),
                   .data_pins_in(pins.data), .data_pins_out(data_pins_out),
                   .data_oe_n(data_oe_n), .sec_bit1(sec_bit1), .sec_bit2(sec_bit2),
                   .erase_busy(erase_busy));
   // Clock of 5 ns period.
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // Cut a hang short.
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         n_errors++;
         final_report();
      end
   end
   // Compare a byte.
   task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check8
   // Compare a single bit.
   task automatic check1(input string what, input logic exp, input logic got);
      check8(what, {7'h00, exp}, {7'h00, got});
   endtask : check1
   // Verify read that must be driven with the expected byte.
   task automatic verify(input logic [`EPV_ADDR_W-1:0] a, input logic [7:0] exp);
      u_prog.read_loc(`EPV_CODE_VER, a, v, drove);
      check1("verify drive", 1'b1, drove);
      check8("verify byte", exp, v);
   endtask : verify
   // Fresh array, clear security bits and identity bytes.
   task automatic t_blank;
      #1;
      check1("erase busy", 1'b1, erase_busy);
      // Verify reads are only served once the erase sweep has finished.
      wait (erase_busy == 1'b0);
      check1("security bit 1", 1'b0, sec_bit1);
      check1("security bit 2", 1'b0, sec_bit2);
      verify(12'h123, `EPV_ERASED);
      verify(12'hFFF, `EPV_ERASED);
      u_prog.read_loc(`EPV_CODE_SIG, `EPV_SIG_ADDR0, v, drove);
      check8("maker byte", `EPV_ID_MAKER, v);
      u_prog.read_loc(`EPV_CODE_SIG, `EPV_SIG_ADDR1, v, drove);
      check8("part byte", `EPV_ID_PART, v);
   endtask : t_blank
   // Back-to-back writes, including the top address.
   task automatic t_write;
      u_prog.pgm_loc(`EPV_CODE_PGM, 12'h123, 8'h3C);
      u_prog.pgm_loc(`EPV_CODE_PGM, 12'hFFF, 8'h00);
      verify(12'h123, 8'h3C);
      verify(12'hFFF, 8'h00);
   endtask : t_write
   // A short pulse train and undefined codes leave the array alone.
   task automatic t_abort;
      u_prog.set_mode(`EPV_CODE_PGM, 12'h200, 8'h55, 1'b1);
      u_prog.pulses(`EPV_PULSE_LAST);
      verify(12'h200, `EPV_ERASED);
      u_prog.read_loc(4'h5, 12'h123, v, drove);
      check1("undefined drive", 1'b0, drove);
      u_prog.pgm_loc(4'h9, 12'h300, 8'h00);
      verify(12'h300, `EPV_ERASED);
   endtask : t_abort
   // Fill the table; reads come back encrypted.
   task automatic t_encrypt;
      for (int i = 0; i < `EPV_ENC_DEPTH; i++)
         u_prog.pgm_loc(`EPV_CODE_ENC, 12'(i), 8'h0F);
      verify(12'h123, ~(8'h3C ^ 8'h0F));
      verify(12'hFFF, ~(8'h00 ^ 8'h0F));
   endtask : t_encrypt
   // Security bits lock writes, then reads.
   task automatic t_secure;
      u_prog.pgm_loc(`EPV_CODE_SEC1, 12'h000, 8'h00);
      check1("security bit 1", 1'b1, sec_bit1);
      u_prog.pgm_loc(`EPV_CODE_PGM, 12'h400, 8'h11);
      u_prog.pgm_loc(`EPV_CODE_ENC, 12'h000, 8'hFF);
      verify(12'h400, ~(`EPV_ERASED ^ 8'h0F));
      u_prog.pgm_loc(`EPV_CODE_SEC2, 12'h000, 8'h00);
      check1("security bit 2", 1'b1, sec_bit2);
      u_prog.read_loc(`EPV_CODE_VER, 12'h123, v, drove);
      check1("locked drive", 1'b0, drove);
   endtask : t_secure
   // Print the counts and the verdict, then stop.
   task automatic final_report;
      $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : final_report
   // Reset for two cycles, then run every scenario.
   initial
   begin
      nrst            = 1'b0;
      n_errors        = 0;
      samples_checked = 0;
      cycles          = 0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t_blank();
      t_write();
      t_abort();
      t_encrypt();
      t_secure();
      final_report();
   end
endmodule : epv_port_bench

/* File: verif/epv_programmer.sv */
`timescale 1ns/1ps
`include "epv_defs.svh"
// Programmer model: sets the mode pins, pulses the strobe and pulls port 0 up.
module epv_programmer #(
   parameter int SETTLE = 32, // Setup and hold cycles around the pulses.
   parameter int LOW_W  = 20, // Strobe low cycles in each pulse.
   parameter int HIGH_W = 4   // Strobe high cycles between pulses.
) (
   input  wire logic         ref_clk,       // Shared clock.
   input  wire logic [7:0]   data_pins_out, // Port 0 value from the device.
   input  wire logic         data_oe_n,     // Device drives port 0 while low.
   output epv_pkg::epv_pins_t pins          // Pin levels as seen on the wire.
);
   epv_pkg::epv_pins_t ctl;   // Levels set by the tasks.
   logic               drive; // Programmer drives port 0.
   // Port 0 shows the device, else the programmer, else the pull-ups.
   always_comb
   begin
      pins      = ctl;
      pins.data = !data_oe_n ? data_pins_out : (drive ? ctl.data : 8'hFF);
   end
   // Reset pin high and fetch strobe low in every mode.
   initial
   begin
      ctl         = '0;
      ctl.rst_pin = 1'b1;
      ctl.strobe  = 1'b1;
      drive       = 1'b0;
   end
   // Mode, address and data change together; the voltage follows enable select.
   task automatic set_mode(input logic [3:0] code, input logic [`EPV_ADDR_W-1:0] a,
                           input logic [7:0] d, input logic drv);
      @(posedge ref_clk);
      {ctl.en, ctl.ma, ctl.mb, ctl.mc} <= code;
      ctl.addr <= a;
      ctl.data <= d;
      ctl.vpp  <= 1'b0;
      drive    <= drv;
      repeat (SETTLE) @(posedge ref_clk);
      ctl.vpp <= code[3];
      repeat (SETTLE) @(posedge ref_clk);
   endtask : set_mode
   // Pulse the strobe low n times, then keep address and data held.
   task automatic pulses(input int n);
      repeat (n)
      begin
         ctl.strobe <= 1'b0;
         repeat (LOW_W) @(posedge ref_clk);
         ctl.strobe <= 1'b1;
         repeat (HIGH_W) @(posedge ref_clk);
      end
      repeat (SETTLE) @(posedge ref_clk);
   endtask : pulses
   // One full location write.
   task automatic pgm_loc(input logic [3:0] code, input logic [`EPV_ADDR_W-1:0] a,
                          input logic [7:0] d);
      set_mode(code, a, d, 1'b1);
      pulses(`EPV_PULSES);
   endtask : pgm_loc
   // Read after the output settle time of 48 periods at 6 MHz, since old data may linger.
   task automatic read_loc(input logic [3:0] code, input logic [`EPV_ADDR_W-1:0] a,
                           output logic [7:0] v, output logic drove);
      set_mode(code, a, 8'h00, 1'b0);
      repeat (`EPV_OSC_PERIODS * `EPV_OSC_MIN_NS / `EPV_CLK_NS) @(posedge ref_clk);
      #1;
      v     = pins.data;
      drove = !data_oe_n;
   endtask : read_loc
endmodule : epv_programmer
